// ---- verilog/sric_reclock_ctrl.sv ----
// Input selection, lock, bypass, mute and register logic of the reclocker
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sric_reclock_ctrl #(
    parameter int unsigned LOS_CYCLES = sric_pkg::LOS_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] serial_input_channels,
    input wire logic input_select_lsb,
    input wire logic input_select_msb,
    input wire logic clock_out_select,
    input wire logic bypass_force,
    input wire logic mute_n,
    input wire logic cdr_locked,
    input wire sric_pkg::sric_rate_t cdr_rate,
    input wire logic recovered_clk_phase,
    output sric_pkg::sric_diff_t primary_serial_out,
    output sric_pkg::sric_diff_t secondary_serial_out,
    output logic lock_indicator,
    output logic irq,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import sric_pkg::*;

    logic [3:0] chan_s1_ff; // First sync stage, inputs
    logic [3:0] chan_s2_ff; // Second sync stage, inputs
    sric_pins_t pins_s1_ff; // First sync stage, pins
    sric_pins_t pins_s2_ff; // Second sync stage, pins
    logic cdr_s1_ff; // Loop lock, first stage
    logic cdr_s2_ff; // Loop lock, second stage
    logic rclk_s1_ff; // Clock phase, first stage
    logic rclk_s2_ff; // Clock phase, second stage
    sric_rate_t rate_s1_ff; // Rate class, first stage
    sric_rate_t rate_s2_ff; // Rate class, second stage

    logic chosen_w; // Selected input bit
    logic sample_ff; // Retimed sample
    logic prev_ff; // Previous retimed sample
    logic rclk_r_ff; // Clock phase aligned with the retimed sample
    logic [1:0] sel_prev_ff; // Selection last cycle
    logic transition_w; // Edge seen on selected input
    logic sel_chg_w; // Selection changed
    logic [LOS_W-1:0] los_cnt_ff; // Cycles since last edge
    logic active_w; // Data present
    logic good_w; // All lock conditions hold
    logic [SETTLE_W-1:0] settle_ff; // Good cycles in acquisition
    sric_state_t state_ff; // Lock state
    sric_state_t nxt_state; // Next lock state
    logic nxt_lock_w; // Lock next cycle

    logic [1:0] ctrl_ff; // Software mute and bypass
    logic [2:0] irq_stat_ff; // Sticky events
    logic [2:0] irq_mask_ff; // Event enables
    logic [2:0] nxt_irq_stat; // Events after set and clear
    logic [2:0] nxt_irq_mask; // Mask after write
    logic [2:0] irq_ev_w; // Events this cycle
    logic wait_ff; // Bus wait
    logic [31:0] rdata_ff; // Bus read data
    logic wr_w; // Write taken this edge
    logic [2:0] wbyte_w; // Low write lane bits

    logic mute_w; // Both outputs muted
    logic bypass_w; // Unretimed data path
    logic sec_mute_w; // Secondary muted
    logic data_w; // Data for outputs
    sric_diff_t primary_ff; // Primary output pair
    sric_diff_t secondary_ff; // Secondary output pair
    logic lock_ff; // Lock indicator
    logic irq_ff; // Interrupt line
    sric_status_t status_ff; // Status word

    // Two-flop synchronisers for all asynchronous inputs
    always_ff @(posedge clk) begin
        if (reset) begin
            chan_s1_ff <= 4'h0;
            chan_s2_ff <= 4'h0;
            pins_s1_ff <= PINS_RST;
            pins_s2_ff <= PINS_RST;
            cdr_s1_ff <= 1'b0;
            cdr_s2_ff <= 1'b0;
            rclk_s1_ff <= 1'b0;
            rclk_s2_ff <= 1'b0;
            rate_s1_ff <= RATE_NONE;
            rate_s2_ff <= RATE_NONE;
        end else begin
            chan_s1_ff <= serial_input_channels;
            chan_s2_ff <= chan_s1_ff;
            pins_s1_ff <= '{sel: {input_select_msb, input_select_lsb},
                            clk_out_sel: clock_out_select,
                            bypass: bypass_force, mute_n: mute_n};
            pins_s2_ff <= pins_s1_ff;
            cdr_s1_ff <= cdr_locked;
            cdr_s2_ff <= cdr_s1_ff;
            rclk_s1_ff <= recovered_clk_phase;
            rclk_s2_ff <= rclk_s1_ff;
            rate_s1_ff <= cdr_rate;
            rate_s2_ff <= rate_s1_ff;
        end
    end

    // Input multiplexer, code n picks channel n
    assign chosen_w = chan_s2_ff[pins_s2_ff.sel];

    // Retiming stage and edge detection
    always_ff @(posedge clk) begin
        if (reset) begin
            sample_ff <= 1'b0;
            prev_ff <= 1'b0;
            rclk_r_ff <= 1'b0;
            sel_prev_ff <= 2'h0;
        end else begin
            sample_ff <= chosen_w;
            prev_ff <= sample_ff;
            rclk_r_ff <= rclk_s2_ff;
            sel_prev_ff <= pins_s2_ff.sel;
        end
    end

    assign transition_w = sample_ff ^ prev_ff;
    assign sel_chg_w = sel_prev_ff != pins_s2_ff.sel;

    // Loss-of-signal counter, saturating
    always_ff @(posedge clk) begin
        if (reset) begin
            los_cnt_ff <= LOS_W'(LOS_CYCLES);
        end else if (sel_chg_w) begin
            los_cnt_ff <= LOS_W'(LOS_CYCLES);
        end else if (transition_w) begin
            los_cnt_ff <= '0;
        end else if (los_cnt_ff < LOS_W'(LOS_CYCLES)) begin
            los_cnt_ff <= los_cnt_ff + 1'b1;
        end
    end

    assign active_w = los_cnt_ff < LOS_W'(LOS_CYCLES);
    // Supported rate covers 143, 270 (also 8b/10b streams) and both HD rates
    assign good_w = cdr_s2_ff && rate_supported(rate_s2_ff) && active_w
                    && !sel_chg_w;

    // Lock state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            // Wait for first transition
            ST_IDLE: begin
                if (transition_w && !sel_chg_w) begin
                    nxt_state = ST_ACQ;
                end
            end
            // Count good cycles
            ST_ACQ: begin
                if (!active_w || sel_chg_w) begin
                    nxt_state = ST_IDLE;
                end else if (good_w && settle_ff == SETTLE_W'(SETTLE_CYCLES - 1)) begin
                    nxt_state = ST_LOCK;
                end
            end
            // Drop on any bad condition
            ST_LOCK: begin
                if (!good_w) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    assign nxt_lock_w = nxt_state == ST_LOCK;

    // State and settle counter
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            settle_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_ACQ && good_w) begin
                settle_ff <= settle_ff + 1'b1;
            end else begin
                settle_ff <= '0;
            end
        end
    end

    // Output control
    assign mute_w = !pins_s2_ff.mute_n || ctrl_ff[CTRL_SW_MUTE];
    assign bypass_w = pins_s2_ff.bypass || ctrl_ff[CTRL_SW_BYPASS]
                      || !nxt_lock_w;
    assign sec_mute_w = mute_w || (pins_s2_ff.clk_out_sel && bypass_w);
    assign data_w = bypass_w ? chosen_w : sample_ff;

    // Output pairs, muted legs held opposite
    always_ff @(posedge clk) begin
        if (reset) begin
            primary_ff <= DIFF_MUTED;
            secondary_ff <= DIFF_MUTED;
        end else begin
            if (mute_w) begin
                primary_ff <= DIFF_MUTED;
            end else begin
                primary_ff <= '{p: data_w, n: !data_w};
            end
            if (sec_mute_w) begin
                secondary_ff <= DIFF_MUTED;
            end else if (pins_s2_ff.clk_out_sel) begin
                secondary_ff <= '{p: rclk_r_ff, n: !rclk_r_ff};
            end else begin
                secondary_ff <= '{p: data_w, n: !data_w};
            end
        end
    end

    // Lock indicator and status
    always_ff @(posedge clk) begin
        if (reset) begin
            lock_ff <= 1'b0;
            status_ff <= '0;
        end else begin
            lock_ff <= nxt_lock_w;
            status_ff.locked <= nxt_lock_w;
            status_ff.sel <= pins_s2_ff.sel;
            status_ff.clk_mode <= pins_s2_ff.clk_out_sel;
            status_ff.bypass <= bypass_w;
            status_ff.muted <= mute_w;
            status_ff.sec_muted <= sec_mute_w;
            status_ff.sd_rate <= nxt_lock_w
                                 && (rate_s2_ff == RATE_143 || rate_s2_ff == RATE_270);
        end
    end

    // Bus: one wait cycle, then taken
    assign wr_w = avs_write && !wait_ff && avs_byteenable[0];
    assign wbyte_w = avs_writedata[2:0];

    always_ff @(posedge clk) begin
        if (reset) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0;
        end else begin
            wait_ff <= !((avs_read || avs_write) && wait_ff);
            if (avs_read && wait_ff) begin
                if (reg_hit(avs_address, OFS_CTRL)) begin
                    rdata_ff <= 32'(ctrl_ff);
                end else if (reg_hit(avs_address, OFS_STATUS)) begin
                    rdata_ff <= 32'(status_ff);
                end else if (reg_hit(avs_address, OFS_IRQ_STAT)) begin
                    rdata_ff <= 32'(irq_stat_ff);
                end else if (reg_hit(avs_address, OFS_IRQ_MASK)) begin
                    rdata_ff <= 32'(irq_mask_ff);
                end else begin
                    rdata_ff <= 32'h0; // Unmapped
                end
            end
        end
    end

    // Control register
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_ff <= CTRL_RST;
        end else if (wr_w && reg_hit(avs_address, OFS_CTRL)) begin
            ctrl_ff <= wbyte_w[1:0];
        end
    end

    // Events: set wins over write-one-to-clear
    assign irq_ev_w[IRQ_LOCK_RISE] = nxt_lock_w && !lock_ff;
    assign irq_ev_w[IRQ_LOCK_FALL] = !nxt_lock_w && lock_ff;
    assign irq_ev_w[IRQ_UNSUP] = rate_s2_ff == RATE_UNSUP;

    always_comb begin
        nxt_irq_stat = irq_stat_ff;
        nxt_irq_mask = irq_mask_ff;
        if (wr_w && reg_hit(avs_address, OFS_IRQ_STAT)) begin
            nxt_irq_stat = irq_stat_ff & ~wbyte_w;
        end
        if (wr_w && reg_hit(avs_address, OFS_IRQ_MASK)) begin
            nxt_irq_mask = wbyte_w;
        end
        nxt_irq_stat = nxt_irq_stat | irq_ev_w;
    end

    // Interrupt registers and line
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_stat_ff <= IRQ_RST;
            irq_mask_ff <= IRQ_RST;
            irq_ff <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
        end
    end

    // Outputs from flops
    assign primary_serial_out = primary_ff;
    assign secondary_serial_out = secondary_ff;
    assign lock_indicator = lock_ff;
    assign irq = irq_ff;
    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_route_retimed: assert property (
        !status_ff.muted && !status_ff.bypass |-> primary_ff.p == $past(chosen_w, 2))
        else $error("retimed output not from selected input");
    chk_clock_mode: assert property (
        status_ff.clk_mode && !status_ff.sec_muted |-> secondary_ff.p == $past(rclk_r_ff))
        else $error("secondary not carrying clock");
    chk_mute_both: assert property (
        !pins_s2_ff.mute_n |=> primary_ff == DIFF_MUTED && secondary_ff == DIFF_MUTED)
        else $error("mute did not silence outputs");
    chk_clk_bypass_mute: assert property (
        pins_s2_ff.clk_out_sel && pins_s2_ff.bypass |=> secondary_ff == DIFF_MUTED)
        else $error("clock output not muted in bypass");
    chk_legs_opposite: assert property (
        primary_ff.p != primary_ff.n && secondary_ff.p != secondary_ff.n)
        else $error("differential legs equal");
    chk_lock_supported: assert property (
        lock_indicator |-> $past(good_w))
        else $error("lock without supported rate");
    chk_unsup_bypass: assert property (
        rate_s2_ff == RATE_UNSUP |=> !lock_indicator && status_ff.bypass)
        else $error("unsupported rate not bypassed");

    chk_lock_settle: assert property (
        $rose(lock_indicator) |-> $past(state_ff) == ST_ACQ
                                  && $past(settle_ff) == SETTLE_W'(SETTLE_CYCLES - 1))
        else $error("lock before settle time");

    chk_force_bypass: assert property (
        pins_s2_ff.bypass |=> status_ff.bypass)
        else $error("bypass pin ignored");

    chk_sync_delay: assert property (
        (!mute_n) [*3] |=> primary_ff == DIFF_MUTED)
        else $error("mute pin not effective after sync");

endmodule : sric_reclock_ctrl

// ---- verilog/sric_pkg.sv ----
// Shared constants, carriers and helpers of the reclocker control block
package sric_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 5; // 200 MHz
    localparam int unsigned LOS_TIME_NS = 1000000; // Longest wait for a transition
    localparam int unsigned LOS_CYCLES_DEF = LOS_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_TIME_NS = 1000; // Least time good before lock
    localparam int unsigned SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOS_W = 20; // Loss counter width
    localparam int unsigned SETTLE_W = 8; // Settle counter width

    // Register bus
    localparam int unsigned ADDR_W = 6;
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_STATUS = 6'h04;
    localparam logic [5:0] OFS_IRQ_STAT = 6'h08;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h0C;

    // Control register fields
    localparam int unsigned CTRL_SW_MUTE = 0;
    localparam int unsigned CTRL_SW_BYPASS = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // Interrupt fields
    localparam int unsigned IRQ_LOCK_RISE = 0;
    localparam int unsigned IRQ_LOCK_FALL = 1;
    localparam int unsigned IRQ_UNSUP = 2;
    localparam logic [2:0] IRQ_RST = 3'h0;

    // Rate class reported by the clock recovery
    typedef enum logic [2:0] {
        RATE_NONE = 3'h0,
        RATE_143 = 3'h1,
        RATE_270 = 3'h2,
        RATE_1483 = 3'h3,
        RATE_1485 = 3'h4,
        RATE_HARMONIC = 3'h5,
        RATE_UNSUP = 3'h6
    } sric_rate_t;

    // Lock state machine, Gray along idle-acquire-lock
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ACQ = 2'h1,
        ST_LOCK = 2'h3
    } sric_state_t;

    // Static control pins
    typedef struct packed {
        logic [1:0] sel;
        logic clk_out_sel;
        logic bypass;
        logic mute_n;
    } sric_pins_t;

    // Pins after reset: pulled levels
    localparam sric_pins_t PINS_RST = 5'h01;

    // Differential leg pair
    typedef struct packed {
        logic p;
        logic n;
    } sric_diff_t;

    localparam sric_diff_t DIFF_MUTED = 2'h1; // True low, complement high

    // Status word
    typedef struct packed {
        logic sd_rate;
        logic sec_muted;
        logic muted;
        logic bypass;
        logic clk_mode;
        logic [1:0] sel;
        logic locked;
    } sric_status_t;

    // Rates that may be retimed
    function automatic logic rate_supported(input sric_rate_t r);
        return (r == RATE_143) || (r == RATE_270) || (r == RATE_1483) || (r == RATE_1485);
    endfunction : rate_supported

    // Register decode
    function automatic logic reg_hit(input logic [5:0] a, input logic [5:0] ofs);
        return a == ofs;
    endfunction : reg_hit

endpackage : sric_pkg

// ---- dv/sric_far_side.sv ----
// Behavioural far side: serial sources and the analog recovery loop
`timescale 1ns/1ps
module sric_far_side
    import sric_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] active_mask,
    input wire logic loop_locked,
    input wire sric_pkg::sric_rate_t loop_rate,
    output logic [3:0] serial_input_channels,
    output logic cdr_locked,
    output sric_pkg::sric_rate_t cdr_rate,
    output logic recovered_clk_phase
);
    // Active channels toggle each cycle, quiet ones sit low; cables quiet in reset
    always @(posedge clk) begin
        if (reset) begin
            serial_input_channels <= 4'h0;
        end else begin
            serial_input_channels <= (serial_input_channels ^ active_mask) & active_mask;
        end
    end

    // Loop status follows the bench's commands
    always @(posedge clk) begin
        cdr_locked <= loop_locked;
        cdr_rate <= loop_rate;
    end

    // Recovered clock runs only while the loop holds lock
    always @(posedge clk) begin
        if (reset) begin
            recovered_clk_phase <= 1'b0;
        end else begin
            recovered_clk_phase <= loop_locked ? ~recovered_clk_phase : 1'b0;
        end
    end
endmodule : sric_far_side

// ---- dv/tb_sdi_reclock_io_control.sv ----
// Self-checking bench of the reclocker control block
`timescale 1ns/1ps
module tb_sdi_reclock_io_control;
    import sric_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] sel = 2'h0; // Input select pins
    logic clock_out_select = 1'b0;
    logic bypass_force = 1'b0;
    logic mute_n = 1'b1;
    logic [3:0] active_mask = 4'h0; // Toggling far-side channels
    logic loop_locked = 1'b0;
    sric_rate_t loop_rate = RATE_NONE;
    logic [3:0] serial_input_channels;
    logic cdr_locked;
    sric_rate_t cdr_rate;
    logic recovered_clk_phase;
    sric_diff_t primary_serial_out;
    sric_diff_t secondary_serial_out;
    logic lock_indicator;
    logic irq;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] rd; // Last read data
    int tp; // Primary toggles seen
    int ts; // Secondary toggles seen
    logic got; // Lock seen
    sric_rate_t rates [7] = '{RATE_143, RATE_270, RATE_1483, RATE_1485,
        RATE_HARMONIC, RATE_UNSUP, RATE_NONE};

    // 200 MHz clock
    always #2.5 clk = ~clk;

    sric_reclock_ctrl #(.LOS_CYCLES(50)) sric_reclock_ctrl_i (
        .clk(clk), .reset(reset), .serial_input_channels(serial_input_channels),
        .input_select_lsb(sel[0]), .input_select_msb(sel[1]),
        .clock_out_select(clock_out_select), .bypass_force(bypass_force),
        .mute_n(mute_n), .cdr_locked(cdr_locked), .cdr_rate(cdr_rate),
        .recovered_clk_phase(recovered_clk_phase),
        .primary_serial_out(primary_serial_out),
        .secondary_serial_out(secondary_serial_out),
        .lock_indicator(lock_indicator), .irq(irq), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );

    sric_far_side sric_far_side_i (
        .clk(clk), .reset(reset), .active_mask(active_mask), .loop_locked(loop_locked),
        .loop_rate(loop_rate), .serial_input_channels(serial_input_channels),
        .cdr_locked(cdr_locked), .cdr_rate(cdr_rate),
        .recovered_clk_phase(recovered_clk_phase)
    );

    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // Compare one value
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One register access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        // Only the hang guard ends a wait that never ends
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Count output toggles over 16 cycles
    task automatic watch();
        sric_diff_t pp;
        sric_diff_t sp;
        tp = 0;
        ts = 0;
        repeat (16) begin
            pp = primary_serial_out;
            sp = secondary_serial_out;
            @(posedge clk);
            tp += (primary_serial_out !== pp);
            ts += (secondary_serial_out !== sp);
        end
    endtask : watch

    // Wait a bounded time for lock
    task automatic wait_lock(input int lim);
        int i;
        got = 1'b0;
        for (i = 0; i < lim && got !== 1'b1; i++) begin
            @(posedge clk);
            got = (lock_indicator === 1'b1);
        end
    endtask : wait_lock

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            mismatches++;
            results();
        end
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk("primary reset", DIFF_MUTED, primary_serial_out);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("clock mode default", 32'h0, rd[3]);
        bus(1'b1, 6'h10, 32'hFFFFFFFF);
        bus(1'b0, 6'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
        // Writes with lane 0 disabled are refused
        avs_byteenable <= 4'hE;
        bus(1'b1, OFS_CTRL, 32'h3);
        avs_byteenable <= 4'hF;
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("lane 0 off ignored", 32'h0, rd);
        // Lock only at supported rates
        for (int i = 0; i < 7; i++) begin
            loop_locked <= 1'b0;
            active_mask <= 4'h0;
            tick(8);
            loop_rate <= rates[i];
            loop_locked <= 1'b1;
            tick(4);
            active_mask <= 4'h1;
            wait_lock(400);
            chk("lock by rate", i < 4, got);
            if (i == 5) begin
                bus(1'b0, OFS_STATUS, 32'h0);
                chk("unsupported bypass", 32'h1, rd[4]);
            end
        end
        // Sticky events, mask and clear
        bus(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("irq events", 32'h7, rd);
        bus(1'b1, OFS_IRQ_MASK, 32'h4);
        tick(2);
        chk("irq raised", 32'h1, irq);
        bus(1'b1, OFS_IRQ_STAT, 32'h7);
        tick(2);
        chk("irq cleared", 32'h0, irq);
        bus(1'b1, OFS_IRQ_MASK, 32'h0);
        // Relock and check the data mode
        loop_rate <= RATE_270;
        wait_lock(400);
        chk("relock", 32'h1, got);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("retimed path", 32'h0, rd[4]);
        chk("status locked", 32'h1, rd[0]);
        chk("sd rate", 32'h1, rd[7]);
        watch();
        chk("retimed toggles", 32'h10, tp);
        chk("secondary data copy", tp, ts);
        // Clock mode: stop data so only the clock moves
        clock_out_select <= 1'b1;
        active_mask <= 4'h0;
        tick(6);
        watch();
        chk("clock runs", 32'h1, ts > 0 && tp == 0);
        active_mask <= 4'h1;
        bypass_force <= 1'b1;
        tick(6);
        watch();
        chk("bypass passes data", 32'h1, tp > 0);
        chk("clock muted in bypass", DIFF_MUTED, secondary_serial_out);
        mute_n <= 1'b0;
        tick(6);
        watch();
        chk("mute primary", DIFF_MUTED, primary_serial_out);
        chk("mute holds", 32'h0, tp + ts);
        mute_n <= 1'b1;
        clock_out_select <= 1'b0;
        bus(1'b1, OFS_CTRL, 32'h1);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl readback", 32'h1, rd);
        tick(6);
        chk("soft mute", DIFF_MUTED, primary_serial_out);
        bus(1'b1, OFS_CTRL, 32'h0);
        // Every select code picks its own channel
        for (int k = 0; k < 4; k++) begin
            sel <= k[1:0];
            active_mask <= 4'h1 << ((k + 1) % 4);
            tick(6);
            watch();
            chk("other channel quiet", 32'h0, tp);
            active_mask <= 4'h1 << k;
            tick(6);
            watch();
            chk("chosen channel", 32'h1, tp > 0);
        end
        results();
    end
endmodule : tb_sdi_reclock_io_control
